// file: core/sscs_pkg.sv
/*
  Shared constants of the clocked serial unit: register byte offsets,
  field positions, reset values, mode codes and timing counts.
  Assumes a 32-bit APB with byte addresses and one register per word.
*/
package sscs_pkg;

  // Register byte offsets.
  localparam logic [11:0] SSCS_OFF_CTRL_MODE = 12'h000;
  localparam logic [11:0] SSCS_OFF_STATUS = 12'h004;
  localparam logic [11:0] SSCS_OFF_DATA = 12'h008;
  localparam logic [11:0] SSCS_OFF_FIFO = 12'h00C;
  localparam logic [11:0] SSCS_OFF_BAUD = 12'h010;

  // Control (upper byte) and mode (lower byte) field positions.
  localparam int SSCS_CM_PCLR = 15;
  localparam int SSCS_CM_MS = 14;
  localparam int SSCS_CM_SPI = 13;
  localparam int SSCS_CM_RIE = 12;
  localparam int SSCS_CM_TIE = 11;
  localparam int SSCS_CM_BUS_IDLE_IRQ_ENABLE = 10;
  localparam int SSCS_CM_RXE = 9;
  localparam int SSCS_CM_TXE = 8;
  localparam int SSCS_CM_MODE_LSB = 5;
  localparam int SSCS_CM_POL = 3;
  localparam int SSCS_CM_BDS = 2;
  localparam int SSCS_CM_CLOCK_OUTPUT_ENABLE = 1;
  localparam int SSCS_CM_DOE = 0;
  localparam logic [15:0] SSCS_CM_WMASK = 16'h7FEF;

  // Status field positions.
  localparam int SSCS_ST_ECLR = 15;
  localparam int SSCS_ST_AWC = 12;
  localparam int SSCS_ST_ORE = 11;
  localparam int SSCS_ST_RECEIVE_FULL_FLAG = 10;
  localparam int SSCS_ST_TRANSMIT_EMPTY_FLAG = 9;
  localparam int SSCS_ST_TBI = 8;

  // Receive FIFO control field positions.
  localparam int SSCS_FC_FEN = 0;
  localparam int SSCS_FC_IDLE = 1;
  localparam int SSCS_FC_LVL_LSB = 8;
  localparam int SSCS_FC_CNT_LSB = 16;

  // Operation mode codes.
  localparam logic [2:0] SSCS_MODE_ASYNC = 3'b000;
  localparam logic [2:0] SSCS_MODE_MULTI = 3'b001;
  localparam logic [2:0] SSCS_MODE_SYNC = 3'b010;
  localparam logic [2:0] SSCS_MODE_LIN = 3'b011;
  localparam logic [2:0] SSCS_MODE_IIC = 3'b100;

  // Reset values.
  localparam logic [15:0] SSCS_RST_CTRL_MODE = 16'h0000;
  localparam logic SSCS_RST_TRANSMIT_EMPTY_FLAG = 1'b1;
  localparam logic SSCS_RST_TBI = 1'b1;
  localparam logic [14:0] SSCS_RST_BAUD = 15'h0004;

  // Receive idle timeout in baud clocks.
  localparam logic [3:0] SSCS_IDLE_BAUD_CLOCKS = 4'h8;

endpackage : sscs_pkg

// file: core/sscs_core.sv
/*
  Clocked serial unit in synchronous mode: control, mode and status
  registers over APB, baud generator, shift engine for master and slave,
  small receive FIFO and the three interrupt request lines.
  Assumes one clock pclk, serial pins outside its domain, and a GPIO
  layer outside that resolves pin output enables.
*/
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module sscs_core #(
  parameter int DATA_BITS = 8,
  parameter int FIFO_DEPTH = 4
) (
  // Clock, reset and enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Serial pins
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Interrupt requests
  output logic rx_irq,
  output logic tx_irq,
  output logic idle_irq
);
  import sscs_pkg::*;

  localparam int CW = $clog2(DATA_BITS + 1);
  localparam int HW = $clog2(2 * DATA_BITS);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int FW = $clog2(FIFO_DEPTH + 1);
  localparam logic [CW-1:0] LAST_BIT = CW'(DATA_BITS - 1);
  localparam logic [HW-1:0] LAST_HALF = HW'(2 * DATA_BITS - 1);
  localparam logic [FW-1:0] FIFO_FULL = FW'(FIFO_DEPTH);

  typedef struct packed {
    logic [15:0] cm;
    logic access_width_select;
    logic overrun_flag;
    logic receive_full_flag;
    logic transmit_empty_flag;
    logic transmit_bus_idle_flag;
    logic [DATA_BITS-1:0] transmit_data_register;
    logic [DATA_BITS-1:0] receive_data_register;
    logic fen;
    logic idle_en;
    logic [FW-1:0] lvl;
    logic [FIFO_DEPTH-1:0][DATA_BITS-1:0] fmem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [FW-1:0] fcnt;
    logic [3:0] idle_cnt;
    logic [14:0] baud_reload;
    logic [14:0] baud_cnt;
    logic baud_half;
    logic run;
    logic [HW-1:0] half_cnt;
    logic sck_out;
    logic tx_busy;
    logic [DATA_BITS-1:0] tx_sh;
    logic [DATA_BITS-1:0] rx_sh;
    logic [CW-1:0] bit_cnt;
    logic sdo;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic [31:0] prdata;
  } sscs_state_type;

  function automatic sscs_state_type sscs_rst_val();
    sscs_state_type r;
    r = '0;
    r.cm = SSCS_RST_CTRL_MODE;
    r.transmit_empty_flag = SSCS_RST_TRANSMIT_EMPTY_FLAG;
    r.transmit_bus_idle_flag = SSCS_RST_TBI;
    r.transmit_data_register = '1;
    r.baud_reload = SSCS_RST_BAUD;
    r.baud_cnt = SSCS_RST_BAUD;
    r.sck_out = 1'b1;
    r.sdo = 1'b1;
    return r;
  endfunction : sscs_rst_val

  localparam sscs_state_type RST_STATE = sscs_rst_val();

  function automatic logic first_bit(logic [DATA_BITS-1:0] v, logic msb);
    return msb ? v[DATA_BITS-1] : v[0];
  endfunction : first_bit

  function automatic logic [DATA_BITS-1:0] shift_out(
    logic [DATA_BITS-1:0] v, logic msb);
    return msb ? {v[DATA_BITS-2:0], 1'b1} : {1'b1, v[DATA_BITS-1:1]};
  endfunction : shift_out

  sscs_state_type s;
  sscs_state_type n;

  logic ms, spi, receive_enable, transmit_enable, pol, bit_order_select;
  logic sync_ok, tick, rise, fall, samp, drv;
  logic setup, wr, rd, mapped;
  logic hit_cm, hit_st, hit_dat, hit_fifo, hit_baud;
  logic push, pop, ore_set, ore_clr, receive_full_flag_set, receive_full_flag_clr, idle_fire;
  logic pclr;
  logic [31:0] wdat;
  logic [31:0] rmux;
  logic [DATA_BITS-1:0] word;
  logic [DATA_BITS-1:0] head;

  always_comb
  begin
    n = s;
    ms = s.cm[SSCS_CM_MS];
    spi = s.cm[SSCS_CM_SPI];
    receive_enable = s.cm[SSCS_CM_RXE];
    transmit_enable = s.cm[SSCS_CM_TXE];
    pol = s.cm[SSCS_CM_POL];
    bit_order_select = s.cm[SSCS_CM_BDS];
    push = 1'b0;
    pop = 1'b0;
    ore_set = 1'b0;
    receive_full_flag_set = 1'b0;
    idle_fire = 1'b0;
    word = '0;
    head = s.fmem[s.rd_ptr];
    sync_ok = (s.cm[7:SSCS_CM_MODE_LSB] == SSCS_MODE_SYNC);

    // The second stage of each synchroniser feeds logic; the clock's third stage also feeds edge detection.
    n.sck_s1 = sck_in;
    n.sck_s2 = s.sck_s1;
    n.sck_s3 = s.sck_s2;
    n.sdi_s1 = sdi;
    n.sdi_s2 = s.sdi_s1;

    tick = (s.baud_cnt == 15'h0000);
    n.baud_cnt = tick ? s.baud_reload : s.baud_cnt - 15'h0001;
    if (tick)
    begin
      n.baud_half = ~s.baud_half;
    end

    // Master makes its own edges; the slave uses the pin clock.
    if (!ms)
    begin
      rise = sync_ok & s.run & tick & ~s.sck_out;
      fall = sync_ok & s.run & tick & s.sck_out;
    end
    else
    begin
      rise = sync_ok & s.sck_s2 & ~s.sck_s3;
      fall = sync_ok & ~s.sck_s2 & s.sck_s3;
    end
    samp = (pol == spi) ? rise : fall;
    drv = (pol == spi) ? fall : rise;

    // APB decode.
    setup = psel & ~penable;
    wr = ce & psel & penable & pwrite;
    rd = ce & psel & penable & ~pwrite;
    hit_cm = 1'b0;
    hit_st = 1'b0;
    hit_dat = 1'b0;
    hit_fifo = 1'b0;
    hit_baud = 1'b0;
    if (paddr == SSCS_OFF_CTRL_MODE)
      hit_cm = 1'b1;
    else if (paddr == SSCS_OFF_STATUS)
      hit_st = 1'b1;
    else if (paddr == SSCS_OFF_DATA)
      hit_dat = 1'b1;
    else if (paddr == SSCS_OFF_FIFO)
      hit_fifo = 1'b1;
    else if (paddr == SSCS_OFF_BAUD)
      hit_baud = 1'b1;
    mapped = hit_cm | hit_st | hit_dat | hit_fifo | hit_baud;
    wdat = s.access_width_select ? pwdata : {16'h0000, pwdata[15:0]};
    pclr = wr & hit_cm & pwdata[SSCS_CM_PCLR];
    ore_clr = wr & hit_st & pwdata[SSCS_ST_ECLR];
    receive_full_flag_clr = rd & hit_dat & ~s.fen;

    // Read data is fetched in the setup phase and shown in access.
    rmux = 32'h0000_0000;
    if (hit_cm)
      rmux = {16'h0000, s.cm};
    else if (hit_st)
      rmux = {16'h0000, 3'b000, s.access_width_select, s.overrun_flag, s.receive_full_flag, s.transmit_empty_flag, s.transmit_bus_idle_flag,
              8'h00};
    else if (hit_dat)
      rmux = 32'(s.fen ? head : s.receive_data_register);
    else if (hit_fifo)
      rmux = (32'(s.fcnt) << SSCS_FC_CNT_LSB)
           | (32'(s.lvl) << SSCS_FC_LVL_LSB)
           | (32'(s.idle_en) << SSCS_FC_IDLE) | 32'(s.fen);
    else if (hit_baud)
      rmux = {17'h0_0000, s.baud_reload};
    if (!s.access_width_select)
    begin
      rmux[31:16] = 16'h0000;
    end
    if (setup)
    begin
      n.prdata = rmux;
    end

    // Master clock generation.
    if (s.run && tick)
    begin
      n.sck_out = ~s.sck_out;
      n.half_cnt = s.half_cnt + 1'b1;
      if (s.half_cnt == LAST_HALF)
      begin
        n.run = 1'b0;
      end
    end

    // Loading the shifter empties the data register.
    if (sync_ok && transmit_enable && !s.transmit_empty_flag && !s.tx_busy && !s.run
        && s.bit_cnt == '0)
    begin
      n.tx_busy = 1'b1;
      n.transmit_empty_flag = 1'b1;
      if (spi)
      begin
        n.sdo = first_bit(s.transmit_data_register, bit_order_select);
        n.tx_sh = shift_out(s.transmit_data_register, bit_order_select);
      end
      else
      begin
        n.tx_sh = s.transmit_data_register;
      end
      if (!ms)
      begin
        n.run = 1'b1;
        n.half_cnt = '0;
      end
    end

    if (drv && s.tx_busy)
    begin
      n.sdo = first_bit(s.tx_sh, bit_order_select);
      n.tx_sh = shift_out(s.tx_sh, bit_order_select);
    end

    if (samp && (s.tx_busy || receive_enable))
    begin
      if (bit_order_select)
        n.rx_sh = {s.rx_sh[DATA_BITS-2:0], s.sdi_s2};
      else
        n.rx_sh = {s.sdi_s2, s.rx_sh[DATA_BITS-1:1]};
      n.bit_cnt = s.bit_cnt + 1'b1;
      if (s.bit_cnt == LAST_BIT)
      begin
        n.bit_cnt = '0;
        n.tx_busy = 1'b0;
        word = n.rx_sh;
        if (receive_enable && s.fen)
        begin
          if (s.fcnt == FIFO_FULL)
          begin
            ore_set = 1'b1;
            n.fen = 1'b0;
          end
          else
          begin
            push = 1'b1;
          end
        end
        else if (receive_enable)
        begin
          ore_set = s.receive_full_flag;
          n.receive_data_register = word;
          receive_full_flag_set = 1'b1;
        end
      end
    end

    // Disabling cuts the word off without waiting for its end.
    if (!transmit_enable || !sync_ok)
    begin
      n.tx_busy = 1'b0;
      n.run = 1'b0;
    end
    if (!receive_enable && !n.tx_busy)
    begin
      n.bit_cnt = '0;
    end

    // Receive FIFO.
    pop = rd & hit_dat & s.fen & (s.fcnt != '0);
    if (push)
    begin
      n.fmem[s.wr_ptr] = word;
      n.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      n.rd_ptr = s.rd_ptr + 1'b1;
    end
    n.fcnt = s.fcnt + FW'(push) - FW'(pop);

    // Idle timer runs only with a partly filled FIFO and a quiet line.
    if (!s.fen || !s.idle_en || s.fcnt == '0 || s.fcnt >= s.lvl
        || s.bit_cnt != '0 || (rd && hit_dat))
    begin
      n.idle_cnt = 4'h0;
    end
    else if (tick && s.baud_half)
    begin
      if (s.idle_cnt == SSCS_IDLE_BAUD_CLOCKS)
        idle_fire = 1'b1;
      else
        n.idle_cnt = s.idle_cnt + 4'h1;
    end

    if (s.fen)
    begin
      if (n.fcnt == '0)
        n.receive_full_flag = 1'b0;
      else if ((s.lvl != '0 && n.fcnt >= s.lvl) || idle_fire)
        n.receive_full_flag = 1'b1;
    end
    else
    begin
      n.receive_full_flag = receive_full_flag_set | (s.receive_full_flag & ~receive_full_flag_clr);
    end
    n.overrun_flag = ore_set | (s.overrun_flag & ~ore_clr);

    // Register writes.
    if (wr && hit_cm)
    begin
      n.cm = pwdata[15:0] & SSCS_CM_WMASK;
    end
    if (wr && hit_st)
    begin
      n.access_width_select = pwdata[SSCS_ST_AWC];
    end
    if (wr && hit_dat)
    begin
      n.transmit_data_register = wdat[DATA_BITS-1:0];
      n.transmit_empty_flag = 1'b0;
    end
    if (wr && hit_fifo)
    begin
      n.fen = pwdata[SSCS_FC_FEN];
      n.idle_en = pwdata[SSCS_FC_IDLE];
      n.lvl = pwdata[SSCS_FC_LVL_LSB +: FW];
    end
    if (wr && hit_baud)
    begin
      n.baud_reload = pwdata[14:0];
      n.baud_cnt = pwdata[14:0];
    end

    // Settings and received data survive a programmable clear; transfer state does not.
    if (pclr)
    begin
      n.run = 1'b0;
      n.tx_busy = 1'b0;
      n.bit_cnt = '0;
      n.half_cnt = '0;
      n.idle_cnt = 4'h0;
      n.baud_cnt = n.baud_reload;
      n.baud_half = 1'b0;
      n.transmit_empty_flag = 1'b1;
      n.receive_full_flag = 1'b0;
      n.overrun_flag = 1'b0;
    end

    if (!n.run)
    begin
      n.sck_out = ~n.cm[SSCS_CM_POL];
    end
    n.transmit_bus_idle_flag = n.transmit_empty_flag & ~n.tx_busy & ~n.run;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= RST_STATE;
    else if (ce)
      s <= n;
  end

  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = s.prdata;
  assign sck_out = s.sck_out;
  assign sck_oe = s.cm[SSCS_CM_CLOCK_OUTPUT_ENABLE];
  assign sdo = s.sdo;
  assign sdo_oe = s.cm[SSCS_CM_DOE];
  assign rx_irq = s.cm[SSCS_CM_RIE] & (s.receive_full_flag | s.overrun_flag);
  assign tx_irq = s.cm[SSCS_CM_TIE] & s.transmit_empty_flag;
  assign idle_irq = s.cm[SSCS_CM_BUS_IDLE_IRQ_ENABLE] & s.transmit_bus_idle_flag;

endmodule : sscs_core

// file: testbench/sscs_peer.sv
/*
  Far-side peer of the serial unit: follows the unit's clock as a slave,
  or makes the link clock itself while the unit is a slave.
  Assumes normal timing, 8-bit words and calls from the bench.
*/
`timescale 1ns/1ps
module sscs_peer (
  // Link settings
  input wire logic pol,
  input wire logic msb,
  input wire logic slave,
  // Serial lines and received word
  input wire logic sck_out,
  input wire logic sdo,
  output logic sck_in,
  output logic sdi,
  output logic [7:0] rx
);
  logic [7:0] tx;
  int n;
  initial
  begin
    sck_in = 1'h1;
    sdi = 1'h1;
    rx = 8'h00;
    tx = 8'h00;
    n = 8;
  end
  task start(input logic [7:0] d);
    tx = d;
    rx = 8'h00;
    n = 0;
  endtask : start
  // Leaving the idle level drives, returning to it samples.
  task step(input logic lvl);
    if (n < 8 && lvl === pol)
      sdi = tx[msb ? 7 - n : n];
    else if (n < 8)
    begin
      rx[msb ? 7 - n : n] = sdo;
      n++;
      // Once hold time is over the line shows the inverse, not a stale bit.
      if (n == 8)
        sdi <= #110 ~sdi;
    end
  endtask : step
  always @(sck_out)
    if (!slave)
      step(sck_out);
  // The link clock runs only inside a frame, 200 ns a period.
  task frame(input logic [7:0] d);
    start(d);
    // Keep pin edges away from the sampling edge of pclk.
    #5;
    repeat (16)
    begin
      #100;
      sck_in = ~sck_in;
      step(sck_in);
    end
  endtask : frame
endmodule : sscs_peer

// file: testbench/sscs_asserts.sv
/*
  Port checker of the serial unit: pin enables, request lines, clock
  idle after abort, write-only bits and unmapped accesses.
  Assumes only the top module's ports; bound after the module.
*/
`timescale 1ns/1ps
module sscs_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins and requests
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic sdo_oe,
  input wire logic rx_irq,
  input wire logic tx_irq,
  input wire logic idle_irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd0;
  assign acc = psel && penable && pwrite && ce && paddr == 12'h000;
  assign rd0 = psel && !penable && !pwrite && ce;
  sck_oe_a: assert property (acc |=> sck_oe == $past(pwdata[1]))
    else $error("clock pin enable differs from written bit");
  sdo_oe_a: assert property (acc |=> sdo_oe == $past(pwdata[0]))
    else $error("data pin enable differs from written bit");
  rx_irq_off_a: assert property (acc && !pwdata[12] |=> !rx_irq)
    else $error("receive request with its enable off");
  tx_irq_off_a: assert property (acc && !pwdata[11] |=> !tx_irq)
    else $error("transmit request with its enable off");
  idle_irq_off_a: assert property (acc && !pwdata[10] |=> !idle_irq)
    else $error("bus idle request with its enable off");
  // Master clock must be back at idle one cycle after the abort lands.
  abort_idle_a: assert property (
    acc && !pwdata[8] && !pwdata[14] |=> ##1 sck_out == !$past(pwdata[3], 2))
    else $error("clock not idle after transmit disable");
  clr_reads0_a: assert property (rd0 && paddr == 12'h000 |=> !prdata[15])
    else $error("clear bit read back as one");
  eclr_reads0_a: assert property (rd0 && paddr == 12'h004 |=> !prdata[15])
    else $error("error clear bit read back as one");
  unmapped_a: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
    else $error("no slave error on unmapped access");
  cover property (acc && pwdata[14]);
  cover property (rx_irq ##1 !rx_irq);
  cover property (acc && !pwdata[8] && !sck_out);
endmodule : sscs_asserts

bind sscs_core sscs_asserts u_chk (.pclk, .presetn, .ce, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pslverr, .sck_out, .sck_oe, .sdo_oe,
  .rx_irq, .tx_irq, .idle_irq);

// file: testbench/sscs_core_tb.sv
/*
  Self-checking bench of the serial unit: registers over APB, request
  lines, mode codes, master and slave words against the peer.
  Assumes the peer model and the bound port checker.
*/
`timescale 1ns/1ps
module sscs_core_tb;
  import sscs_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, sck_in, sck_out, sck_oe, sdi, sdo, sdo_oe;
  logic rx_irq, tx_irq, idle_irq, pol, msb, slave;
  logic [7:0] prx;
  int errors, cmp_count;
  sscs_core DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .sck_in, .sck_out, .sck_oe, .sdi,
    .sdo, .sdo_oe, .rx_irq, .tx_irq, .idle_irq);
  sscs_peer P (.pol, .msb, .slave, .sck_out, .sdo, .sck_in, .sdi, .rx(prx));
  initial
  begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task wrap_up;
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a stalled access.
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task rd(input logic [11:0] a);
    apb(1'h0, a, 32'h0000_0000);
  endtask : rd
  task wait_st(input int b, input logic v);
    int k;
    k = 0;
    do
      rd(SSCS_OFF_STATUS);
    while (q[b] !== v && k++ < 200);
  endtask : wait_st
  // Direction and polarity go in before the enables.
  task cfg(input logic [31:0] c);
    apb(1'h1, SSCS_OFF_CTRL_MODE, c & 32'h0000_40FF);
    apb(1'h1, SSCS_OFF_CTRL_MODE, c);
  endtask : cfg
  task send(input logic [7:0] d, input logic [7:0] p);
    P.start(p);
    apb(1'h1, SSCS_OFF_DATA, 32'(d));
    wait_st(SSCS_ST_TBI, 1'h1);
  endtask : send
  task t_reset;
    rd(SSCS_OFF_CTRL_MODE);
    chk("ctrl_mode", q, 32'h0000_0000);
    rd(SSCS_OFF_STATUS);
    chk("status", q, 32'h0000_0300);
    rd(12'h014);
    chk("unmapped", {q[30:0], err}, 32'h0000_0001);
    chk("pins", 32'({sck_out, sdo, sck_oe, sdo_oe}), 32'h0000_000C);
    ce <= 1'h0;
    @(posedge pclk);
    chk("pready_stall", 32'(pready), 32'h0000_0000);
    ce <= 1'h1;
    @(posedge pclk);
  endtask : t_reset
  task t_irq;
    apb(1'h1, SSCS_OFF_CTRL_MODE, 32'h0000_0C00);
    chk("irq_on", 32'({rx_irq, tx_irq, idle_irq}), 32'h0000_0003);
    apb(1'h1, SSCS_OFF_CTRL_MODE, 32'h0000_1000);
    chk("irq_off", 32'({rx_irq, tx_irq, idle_irq}), 32'h0000_0000);
  endtask : t_irq
  // Other mode codes hold the engine still; switch first, then clear.
  task t_modes;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
    logic [31:0] c;
    foreach (codes[i])
    begin
      c = 32'({codes[i], 5'h00}) | 32'h0000_0100;
      apb(1'h1, SSCS_OFF_CTRL_MODE, c);
      apb(1'h1, SSCS_OFF_DATA, 32'h0000_005A);
      rd(SSCS_OFF_STATUS);
      chk("held", q, 32'h0000_0000);
      apb(1'h1, SSCS_OFF_CTRL_MODE, c | 32'h0000_8000);
      rd(SSCS_OFF_STATUS);
      chk("cleared", q, 32'h0000_0300);
      rd(SSCS_OFF_CTRL_MODE);
      chk("kept", q, c);
    end
  endtask : t_modes
  task t_master;
    for (int i = 0; i < 2; i++)
    begin
      pol = i[0];
      msb = i[0];
      cfg(32'h0000_1343 | 32'({pol, msb, 2'h0}));
      chk("oe", 32'({sck_oe, sdo_oe}), 32'h0000_0003);
      send(8'hB1 ^ {8{pol}}, 8'h6A ^ {8{pol}});
      chk("peer_rx", 32'(prx), 32'(8'hB1 ^ {8{pol}}));
      chk("rx_irq", 32'(rx_irq), 32'h0000_0001);
      rd(SSCS_OFF_STATUS);
      chk("full", q, 32'h0000_0700);
      rd(SSCS_OFF_DATA);
      chk("rx_data", q, 32'(8'h6A ^ {8{pol}}));
      rd(SSCS_OFF_STATUS);
      chk("read_empty", q, 32'h0000_0300);
      chk("sck_idle", 32'(sck_out), 32'(!pol));
    end
  endtask : t_master
  task t_overrun;
    send(8'h11, 8'h22);
    send(8'h33, 8'h44);
    rd(SSCS_OFF_STATUS);
    chk("overrun", 32'(q[11]), 32'h0000_0001);
    apb(1'h1, SSCS_OFF_STATUS, 32'h0000_8000);
    rd(SSCS_OFF_STATUS);
    chk("ovr_clear", 32'({q[15], q[11]}), 32'h0000_0000);
    rd(SSCS_OFF_DATA);
  endtask : t_overrun
  // A slow clock lets the disable land well inside the first bit.
  task t_abort;
    int k;
    pol = 1'h0;
    msb = 1'h0;
    cfg(32'h0000_1343);
    apb(1'h1, SSCS_OFF_BAUD, 32'h0000_0013);
    P.start(8'h00);
    apb(1'h1, SSCS_OFF_DATA, 32'h0000_00F0);
    k = 0;
    do
      @(posedge pclk);
    while (sck_out !== 1'h0 && k++ < 100);
    apb(1'h1, SSCS_OFF_CTRL_MODE, 32'h0000_1243);
    rd(SSCS_OFF_STATUS);
    chk("abort_st", q, 32'h0000_0300);
    chk("abort_idle", 32'(sck_out), 32'h0000_0001);
    apb(1'h1, SSCS_OFF_BAUD, 32'h0000_0003);
  endtask : t_abort
  task t_slave;
    slave = 1'h1;
    cfg(32'h0000_5341);
    chk("slave_oe", 32'(sck_oe), 32'h0000_0000);
    apb(1'h1, SSCS_OFF_DATA, 32'h0000_00C5);
    P.frame(8'h9B);
    @(posedge pclk);
    wait_st(SSCS_ST_RECEIVE_FULL_FLAG, 1'h1);
    chk("slave_tx", 32'(prx), 32'h0000_00C5);
    rd(SSCS_OFF_DATA);
    chk("slave_rx", q, 32'h0000_009B);
  endtask : t_slave
  initial
  begin
    #500000;
    errors++;
    wrap_up();
  end
  initial
  begin
    {presetn, ce, psel, penable, pwrite} = 5'h08;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {pol, msb, slave} = 3'h0;
    errors = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_reset();
    t_irq();
    t_modes();
    apb(1'h1, SSCS_OFF_BAUD, 32'h0000_0003);
    t_master();
    t_overrun();
    t_abort();
    t_slave();
    wrap_up();
  end
endmodule : sscs_core_tb
